//--- pkg/alert_sense_cfg.svh
// Named constants of the alert-output and sense-test sequencer.
// Assumes inclusion by bare name from the design file.
`ifndef ALERT_SENSE_CFG_SVH
`define ALERT_SENSE_CFG_SVH
// Register byte offsets
`define REG_CMD 8'h00
`define REG_CTRL 8'h04
`define REG_STAT 8'h08
`define REG_FILL 8'h0C
// Command register fields
`define CMD_TOP_BIT 16
`define CMD_KIND_BIT 17
// Control register fields
`define CTRL_FILL 0
`define CTRL_EN 1
`define CTRL_PCT 2
`define CTRL_HALT 3
// Status register fields
`define STAT_BUSY 0
`define STAT_FP 1
`define STAT_LP 2
`define STAT_TA 3
`define STAT_FLAG 4
// Opcode loaded for the fill hand-off (55 octal)
`define FILL_OPCODE 6'h2D
// Control-word line numbers
`define LN_C1 1
`define LN_C9 9
`define LN_C10 10
`define LN_C11 11
`define LN_C12 12
`define LN_C17 17
`define LN_C19 19
`define LN_C20 20
`define LN_C21 21
`define LN_C22 22
`define LN_C23 23
// Bus encodings
`define HTRANS_ACTIVE 1
`define WORD_TOP_BIT 11
`endif

//--- pkg/alert_sense_pkg.sv
// Types shared by the alert-output and sense-test sequencer.
// Assumes the constants header sits beside it.
package alert_sense_pkg;
   // Three clock states of one machine cycle
   typedef enum logic [1:0] {ST_FIRST, ST_MID, ST_LAST} clk_state_t;
   // Instruction phase
   typedef enum logic [1:0] {PH_IDLE, PH_OPER, PH_EXEC} phase_t;
   // Instruction kind
   typedef enum logic {K_ALERT, K_SENSE} instr_kind_t;
endpackage

//--- src/alert_and_sense_io_sequencer.sv
// Alert-output / sense-test sequencer with an AHB-Lite register slave.
// Assumes one clock, synchronous inputs and a zero-wait single slave.
`timescale 1ns/1ps
`include "alert_sense_cfg.svh"
module alert_and_sense_io_sequencer #(
   parameter int EA_W = 15
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic HRESP,
   output logic [31:0] HRDATA,
   // Connector lines to equipment
   output logic [23:0] CONTROL_LINES,
   output logic ALERT_STROBE,
   output logic BUFFER_CONTROL_SELECT,
   output logic IO_CHANNEL_SELECT,
   output logic SYSTEM_SELECT,
   output logic TIMING_PULSE_ONE,
   output logic TIMING_PULSE_TWO,
   output logic TEST_STROBE,
   input wire logic CHANNEL_TEST_RESPONSE,
   input wire logic SYSTEM_TEST_RESPONSE,
   // Main frame side
   input wire logic TIMESHARE_ACTIVE,
   input wire logic TIMESHARE_PENDING,
   input wire logic [3:0] BREAKPOINT_SWITCHES,
   output logic CYCLE_ALIGN_STATE,
   output alert_sense_pkg::clk_state_t CLOCK_STATE,
   output logic INSTRUCTION_END,
   output logic INTERRUPT_BLOCK,
   output logic FILL_HANDOFF,
   output logic FLAG_BIT
);
   import alert_sense_pkg::*;

   // Field split of the effective address is fixed by the connector layout
   if (EA_W != 15) begin
      $error("EA_W must be 15");
   end

   clk_state_t st_q; // Clock state within machine cycle
   logic ta_q; // Alternates every machine cycle
   phase_t ph_q; // Instruction phase
   logic fp_q, lp_q; // Subphase bits high and low
   logic pend_q; // Command waiting for a first state
   logic [EA_W-1:0] ea_q; // Effective address, numeric
   logic top_q; // Opcode top bit
   instr_kind_t kind_q; // Alert or sense
   logic [11:0] word_q; // Word register
   logic [2:0] opext_q; // Opcode extension bits
   logic end_q; // End latched at first state
   logic handoff_q; // Fill hand-off pulse
   logic [5:0] fill_op_q; // Opcode given to the fill
   logic fill_q, en_q, pct_q, halt_q, flag_q; // Flags
   logic wr_q; // Write data phase pending
   logic [7:0] addr_q; // Captured write address
   logic [31:0] rdata_q; // Read data
   logic [23:0] cw; // Control word, index = line number

   // Control word assembly; word bit 11 drives line 12
   always_comb begin
      cw = '0;
      cw[`LN_C1] = top_q;
      cw[`LN_C9] = opext_q[2];
      cw[`LN_C10] = opext_q[1];
      cw[`LN_C11] = opext_q[0];
      for (int i = 0; i < 12; i++) begin
         cw[`LN_C12 + i] = word_q[`WORD_TOP_BIT - i];
      end
   end

   // Subphase decode
   wire logic execp = (ph_q == PH_EXEC);
   wire logic exec1 = execp && fp_q && lp_q;
   wire logic exec2 = execp && !fp_q && lp_q;
   wire logic tsw = execp && !fp_q && !lp_q;
   wire logic prew = execp && fp_q && !lp_q;
   wire logic alert = (kind_q == K_ALERT);
   wire logic sense = (kind_q == K_SENSE);
   wire logic s_first = (st_q == ST_FIRST);
   wire logic s_mid = (st_q == ST_MID);
   wire logic s_last = (st_q == ST_LAST);
   wire logic exit_pt = (exec2 || tsw) && s_last;
   wire logic exec_done = exit_pt && !TIMESHARE_ACTIVE;
   wire logic end_cond = !TIMESHARE_PENDING && (sense || !fill_q);
   wire logic fill_go = exec_done && alert && fill_q && !end_q;
   wire logic low_code = !cw[`LN_C1] && !cw[`LN_C10] && !cw[`LN_C11] && !cw[`LN_C17];
   wire logic int_fn = alert && exec2 && s_last && low_code;
   wire logic int_test = low_code && !cw[`LN_C9];
   wire logic ch_sel = !cw[`LN_C1] && !cw[`LN_C10] && cw[`LN_C11];
   logic test_resp; // Selected answer to the control word

   // Sense answer selection
   always_comb begin
      test_resp = ch_sel ? CHANNEL_TEST_RESPONSE : SYSTEM_TEST_RESPONSE;
      if (int_test) begin
         // Breakpoint first, then interrupt enable, then trap flag
         if (cw[`LN_C21]) test_resp = BREAKPOINT_SWITCHES[{cw[`LN_C22], cw[`LN_C23]}];
         else if (cw[`LN_C20]) test_resp = en_q;
         else if (cw[`LN_C19]) test_resp = pct_q;
         else test_resp = 1'b0;
      end
   end

   // Equipment strobes from flops through small gating; INSTRUCTION_END and INTERRUPT_BLOCK also see TIMESHARE_PENDING
   always_comb begin
      ALERT_STROBE = alert && (exec1 || exec2);
      BUFFER_CONTROL_SELECT = ALERT_STROBE && !cw[`LN_C1] && cw[`LN_C10] && !cw[`LN_C11];
      IO_CHANNEL_SELECT = alert && ch_sel && ((exec1 && !s_first) || (exec2 && !s_last));
      SYSTEM_SELECT = alert && exec2 && !s_last
         && !cw[`LN_C9] && cw[`LN_C10] && cw[`LN_C11];
      TIMING_PULSE_ONE = (exec1 && !s_first) || (exec2 && !s_last);
      TIMING_PULSE_TWO = (exec1 && !s_first) || (exec2 && s_first);
      TEST_STROBE = sense && (exec2 || (exec1 && !cw[`LN_C9]));
      INSTRUCTION_END = (exec2 || tsw) && (s_first ? end_cond : end_q);
      INTERRUPT_BLOCK = alert && INSTRUCTION_END;
   end

   assign CONTROL_LINES = cw;
   assign CYCLE_ALIGN_STATE = ta_q;
   assign CLOCK_STATE = st_q;
   assign FILL_HANDOFF = handoff_q;
   assign FLAG_BIT = flag_q;
   assign HREADYOUT = 1'b1; // Never stretches a transfer
   assign HRESP = 1'b0; // Always OKAY
   assign HRDATA = rdata_q;

   // Machine cycle timing; alignment flips at each last state
   always_ff @(posedge CLK) begin
      if (RST) begin
         st_q <= ST_FIRST;
         ta_q <= 1'b0;
      end else begin
         case (st_q)
            ST_FIRST: st_q <= ST_MID;
            ST_MID: st_q <= ST_LAST;
            ST_LAST: begin
               st_q <= ST_FIRST;
               ta_q <= !ta_q;
            end
            default: st_q <= ST_FIRST;
         endcase
      end
   end

   // Bus address phase: capture writes, prepare read data
   wire logic ap = HSEL && HREADY && HTRANS[`HTRANS_ACTIVE];
   always_ff @(posedge CLK) begin
      if (RST) begin
         wr_q <= 1'b0;
         addr_q <= 8'h00;
         rdata_q <= 32'h0;
      end else begin
         wr_q <= ap && HWRITE;
         addr_q <= HADDR[7:0];
         rdata_q <= 32'h0;
         if (ap && !HWRITE) begin
            case (HADDR[7:0])
               `REG_CMD: rdata_q[EA_W+2:0] <= {kind_q, top_q, 1'b0, ea_q};
               `REG_CTRL: rdata_q[`CTRL_HALT:0] <= {halt_q, pct_q, en_q, fill_q};
               `REG_STAT: rdata_q[`STAT_FLAG:0] <=
                  {flag_q, ta_q, lp_q, fp_q, (ph_q != PH_IDLE) || pend_q};
               `REG_FILL: rdata_q[5:0] <= fill_op_q;
               default: rdata_q <= 32'h0; // Unmapped reads zero
            endcase
         end
      end
   end

   wire logic cmd_wr = wr_q && (addr_q == `REG_CMD);
   wire logic ctrl_wr = wr_q && (addr_q == `REG_CTRL);

   // Command intake; writes while busy are dropped
   always_ff @(posedge CLK) begin
      if (RST) begin
         pend_q <= 1'b0;
         ea_q <= '0;
         top_q <= 1'b0;
         kind_q <= K_ALERT;
      end else if (cmd_wr && !pend_q && ph_q == PH_IDLE) begin
         pend_q <= 1'b1;
         ea_q <= HWDATA[EA_W-1:0];
         top_q <= HWDATA[`CMD_TOP_BIT];
         kind_q <= instr_kind_t'(HWDATA[`CMD_KIND_BIT]);
      end else if (pend_q && s_last) begin
         pend_q <= 1'b0;
      end
   end

   // Instruction sequencer
   always_ff @(posedge CLK) begin
      if (RST) begin
         ph_q <= PH_IDLE;
         fp_q <= 1'b0;
         lp_q <= 1'b0;
         word_q <= '0;
         opext_q <= '0;
         end_q <= 1'b0;
         handoff_q <= 1'b0;
         fill_op_q <= '0;
      end else begin
         handoff_q <= 1'b0;
         if (s_first) end_q <= end_cond && (exec2 || tsw);
         case (ph_q)
            PH_IDLE: begin
               // Start aligned to a machine cycle boundary
               if (pend_q && s_last) ph_q <= PH_OPER;
            end
            PH_OPER: begin
               if (s_mid) word_q <= ea_q[11:0];
               if (s_last) begin
                  opext_q <= ea_q[EA_W-1:12];
                  fp_q <= 1'b1;
                  lp_q <= ta_q;
                  ph_q <= PH_EXEC;
               end
            end
            PH_EXEC: begin
               if (prew && s_last && ta_q) lp_q <= 1'b1;
               if (exec1 && s_last) fp_q <= 1'b0;
               if (exit_pt && TIMESHARE_ACTIVE) begin
                  lp_q <= 1'b0;
               end else if (fill_go) begin
                  fill_op_q <= `FILL_OPCODE;
                  fp_q <= 1'b1;
                  lp_q <= 1'b0;
                  handoff_q <= 1'b1;
                  ph_q <= PH_IDLE;
               end else if (exec_done) begin
                  ph_q <= PH_IDLE;
               end
            end
            default: ph_q <= PH_IDLE;
         endcase
      end
   end

   // Flags; hardware actions win over a same-cycle software write, except for the fill flag
   always_ff @(posedge CLK) begin
      if (RST) begin
         fill_q <= 1'b0;
         en_q <= 1'b0;
         pct_q <= 1'b0;
         halt_q <= 1'b0;
         flag_q <= 1'b0;
      end else begin
         // Software arming of a fill wins so a new fill is never lost
         if (ctrl_wr) fill_q <= HWDATA[`CTRL_FILL];
         else if (fill_go) fill_q <= 1'b0;
         if (int_fn && cw[`LN_C20]) en_q <= cw[`LN_C23];
         else if (ctrl_wr) en_q <= HWDATA[`CTRL_EN];
         if (int_fn && cw[`LN_C19]) pct_q <= cw[`LN_C23];
         else if (ctrl_wr) pct_q <= HWDATA[`CTRL_PCT];
         if (int_fn && !cw[`LN_C19] && !cw[`LN_C20] && !cw[`LN_C21] && !cw[`LN_C22]) begin
            halt_q <= 1'b1;
         end else if (ctrl_wr) begin
            halt_q <= HWDATA[`CTRL_HALT];
         end
         if (sense && exec2 && s_last) begin
            flag_q <= test_resp;
         end else if (int_fn && !cw[`LN_C23]) begin
            case ({cw[`LN_C21], cw[`LN_C22]})
               2'h1: flag_q <= 1'b0;
               2'h2: flag_q <= 1'b1;
               2'h3: flag_q <= !flag_q;
               default: flag_q <= flag_q;
            endcase
         end
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   sequence q_pulses;
      (TIMING_PULSE_ONE && TIMING_PULSE_TWO) [*3] ##1
         (TIMING_PULSE_ONE && !TIMING_PULSE_TWO) ##1 (!TIMING_PULSE_ONE && !TIMING_PULSE_TWO);
   endsequence
   sequence ioc_window;
      IO_CHANNEL_SELECT [*4] ##1 !IO_CHANNEL_SELECT;
   endsequence

   a_word_load: assert property ((ph_q == PH_OPER) && s_mid |=> word_q == ea_q[11:0])
      else $error("word register not loaded");
   a_ext_load: assert property ((ph_q == PH_OPER) && s_last |=> opext_q == ea_q[EA_W-1:12])
      else $error("extension bits not loaded");
   a_align_start: assert property ((ph_q == PH_OPER) && s_last |=> (ta_q ? prew : exec1))
      else $error("wrong subphase after operand");
   a_alert_span: assert property (alert && exec1 && s_first |-> ALERT_STROBE [*6] ##1 !ALERT_STROBE)
      else $error("alert strobe span wrong");
   a_buf_select: assert property (BUFFER_CONTROL_SELECT |-> ALERT_STROBE)
      else $error("buffer select without alert");
   a_chan_window: assert property (alert && ch_sel && exec1 && s_mid |-> ioc_window)
      else $error("channel select window wrong");
   a_sys_window: assert property ($rose(SYSTEM_SELECT) |-> exec2 && s_first ##2 !SYSTEM_SELECT)
      else $error("system select window wrong");
   a_pulse_shape: assert property (exec1 && s_mid |-> q_pulses)
      else $error("timing pulse shape wrong");
   a_second_sub: assert property (exec1 && s_last |=> exec2 && s_first)
      else $error("second subphase not entered");
   a_end_gate: assert property ($rose(INSTRUCTION_END) |-> s_first && !TIMESHARE_PENDING)
      else $error("end raised out of place");
   a_fill_hand: assert property (fill_go |=> handoff_q && fill_op_q == `FILL_OPCODE && !fill_q && fp_q)
      else $error("fill hand-off wrong");
   a_ts_wait: assert property (exit_pt && TIMESHARE_ACTIVE |=> tsw)
      else $error("timeshare wait not entered");
   a_test_long: assert property (sense && exec1 && s_first && !cw[`LN_C9] |-> TEST_STROBE [*6])
      else $error("test strobe too short");
   a_flag_store: assert property (sense && exec2 && s_last |=> flag_q == $past(test_resp))
      else $error("flag not stored");
endmodule

//--- bench/io_equipment_model.sv
// Model of the external equipment that answers sense-test control words.
// Assumes the sequencer holds its test strobe over the sampling state.
`timescale 1ns/1ps
module io_equipment_model (
   // Clock
   input wire logic clk,
   // Strobe from the sequencer
   input wire logic test_strobe,
   // Answers chosen by the bench
   input wire logic chan_ans,
   input wire logic sys_ans,
   // Answer lines
   output logic chan_resp,
   output logic sys_resp
);
   logic junk_q = 1'b0; // Changes every cycle, so a stale answer never looks valid

   // Junk pattern while the equipment is not strobed
   always_ff @(posedge clk) begin
      junk_q <= ~junk_q;
   end

   // Answer only while the strobe stands
   assign chan_resp = test_strobe ? chan_ans : junk_q;
   assign sys_resp = test_strobe ? sys_ans : ~junk_q;
endmodule

//--- bench/tb_alert_and_sense_io_sequencer.sv
// Self-checking bench for the alert-output and sense-test sequencer.
// Assumes a zero-wait register slave and the equipment model beside it.
`timescale 1ns/1ps
module tb_alert_and_sense_io_sequencer;
   import alert_sense_pkg::*;
   // Pin activity of one instruction: line image, high counts, end flags
   typedef struct packed {
      logic [23:0] cl;
      logic [3:0] al, bu, io, sy, q1, q2, ts, en, ib;
      logic fl, fg, ta;
   } res_t;
   logic CLK = 1'b0, RST = 1'b1, HSEL = 1'b0, HWRITE = 1'b0;
   logic [31:0] HADDR = '0, HWDATA = '0, HRDATA;
   logic [1:0] HTRANS = '0;
   logic [2:0] HSIZE = 3'h2;
   logic HREADY, HREADYOUT, HRESP, CYCLE_ALIGN_STATE, INSTRUCTION_END, INTERRUPT_BLOCK;
   logic [23:0] CONTROL_LINES;
   logic ALERT_STROBE, BUFFER_CONTROL_SELECT, IO_CHANNEL_SELECT, SYSTEM_SELECT;
   logic TIMING_PULSE_ONE, TIMING_PULSE_TWO, TEST_STROBE, FILL_HANDOFF, FLAG_BIT;
   logic CHANNEL_TEST_RESPONSE, SYSTEM_TEST_RESPONSE;
   logic TIMESHARE_ACTIVE = 1'b0, TIMESHARE_PENDING = 1'b0;
   logic [3:0] BREAKPOINT_SWITCHES = 4'hA;
   clk_state_t CLOCK_STATE;
   logic ans_c = 1'b1, ans_s = 1'b0; // Equipment answers
   logic fill_mod = 0, en_mod = 0, trap_mod = 0, halt_mod = 0, flag_mod = 0; // Expected state
   res_t expq[$]; // Expected results, oldest first
   res_t cur; // Result being gathered
   logic end_q, stb_q;
   int err_count = 0, num_checks = 0;
   // Directed cases: kind, top bit, effective address
   logic [16:0] dir [21] = '{17'h02155, 17'h01155, 17'h03040, 17'h0FFFF, 17'h00004,
      17'h00002, 17'h00006, 17'h00008, 17'h00009, 17'h00010, 17'h00011, 17'h00000,
      17'h10004, 17'h10005, 17'h10006, 17'h10007, 17'h10008, 17'h10010, 17'h10000,
      17'h11155, 17'h1FFFF};

   // Clock and the single slave's ready
   always #25 CLK = ~CLK;
   assign HREADY = HREADYOUT;

   alert_and_sense_io_sequencer dut (.CLK, .RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE,
      .HWDATA, .HREADY, .HREADYOUT, .HRESP, .HRDATA, .CONTROL_LINES, .ALERT_STROBE,
      .BUFFER_CONTROL_SELECT, .IO_CHANNEL_SELECT, .SYSTEM_SELECT, .TIMING_PULSE_ONE,
      .TIMING_PULSE_TWO, .TEST_STROBE, .CHANNEL_TEST_RESPONSE, .SYSTEM_TEST_RESPONSE,
      .TIMESHARE_ACTIVE, .TIMESHARE_PENDING, .BREAKPOINT_SWITCHES, .CYCLE_ALIGN_STATE,
      .CLOCK_STATE, .INSTRUCTION_END, .INTERRUPT_BLOCK, .FILL_HANDOFF, .FLAG_BIT);

   io_equipment_model eq (.clk(CLK), .test_strobe(TEST_STROBE), .chan_ans(ans_c),
      .sys_ans(ans_s), .chan_resp(CHANNEL_TEST_RESPONSE), .sys_resp(SYSTEM_TEST_RESPONSE));

   // Verdict and end of run
   task automatic end_sim;
      if (err_count == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // One comparison
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
      num_checks++;
      if (s !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask

   // Wait for ready at a rising edge, bounded
   task automatic tick_ready;
      int n;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (HREADY !== 1'b1 && n < 50);
      if (HREADY !== 1'b1) begin
         err_count++;
         $display("Error hready expected 1 seen %b", HREADY);
         end_sim;
      end
   endtask

   // One single-word bus transfer, address phase then data phase
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge CLK);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= {24'h0, a};
      HWRITE <= wr;
      tick_ready;
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wd;
      tick_ready;
      rd = HRDATA;
      chk("hresp", 64'h0, {63'h0, HRESP});
   endtask

   // Control register write, mirrored in the expected state
   task automatic set_ctrl(input logic [3:0] v);
      logic [31:0] rd;
      bus(1'b1, 8'h04, {28'h0, v}, rd);
      {halt_mod, trap_mod, en_mod, fill_mod} = v;
   endtask

   // Predict, start and finish one instruction; tsh holds a timeshare over it
   task automatic run(input logic kd, input logic tp, input logic [14:0] ea, input logic tsh);
      res_t e;
      logic [23:0] c;
      logic [31:0] rd;
      int n;
      c = '0;
      c[1] = tp;
      for (n = 0; n < 15; n++) c[9 + n] = ea[14 - n];
      e = '0;
      e.cl = c;
      e.q1 = 4'h4;
      e.q2 = 4'h3;
      e.en = 4'h3;
      if (!kd) begin
         e.al = 4'h6;
         e.bu = (!c[1] && c[10] && !c[11]) ? 4'h6 : 4'h0;
         e.io = (!c[1] && !c[10] && c[11]) ? 4'h4 : 4'h0;
         e.sy = (!c[9] && c[10] && c[11]) ? 4'h2 : 4'h0;
         // Automatic alert of a fill hands off instead of ending
         if (fill_mod) begin
            e.en = 4'h0;
            e.fl = 1'b1;
            fill_mod = 1'b0;
         end
         e.ib = e.en;
         // Internal functions
         if (!c[1] && !c[10] && !c[11] && !c[17]) begin
            if (c[20]) en_mod = c[23];
            if (c[19]) trap_mod = c[23];
            if (c[22:19] == 4'h0) halt_mod = 1'b1;
            if (!c[23] && c[21]) flag_mod = c[22] ? ~flag_mod : 1'b1;
            else if (!c[23] && c[22]) flag_mod = 1'b0;
         end
      end else begin
         e.ts = c[9] ? 4'h3 : 4'h6;
         // Internal test, else the selected equipment answer
         if (c[11:9] == 3'h0 && !c[1] && !c[17])
            flag_mod = c[21] ? BREAKPOINT_SWITCHES[{c[22], c[23]}] : c[20] ? en_mod : c[19] & trap_mod;
         else flag_mod = (!c[1] && !c[10] && c[11]) ? ans_c : ans_s;
      end
      e.fg = flag_mod;
      expq.push_back(e);
      if (tsh) begin
         TIMESHARE_ACTIVE <= 1'b1;
         TIMESHARE_PENDING <= 1'b1;
      end
      bus(1'b1, 8'h00, {14'h0, kd, tp, 1'b0, ea}, rd);
      // A command while busy must leave no trace
      if (tsh) begin
         bus(1'b1, 8'h00, 32'h0002_0000, rd);
         repeat (24) @(posedge CLK);
         // Release at the close of a last state, so the next first state sees no pending
         n = 0;
         do begin
            @(negedge CLK);
            n++;
         end while (CLOCK_STATE !== ST_LAST && n < 4);
         @(posedge CLK);
         TIMESHARE_ACTIVE <= 1'b0;
         TIMESHARE_PENDING <= 1'b0;
      end
      for (n = 0; n < 300 && expq.size() > 0; n++) @(posedge CLK);
      if (expq.size() > 0) begin
         err_count++;
         $display("Error result expected 1 seen 0");
         end_sim;
      end
      bus(1'b0, 8'h04, 32'h0, rd);
      chk("ctrl", {60'h0, halt_mod, trap_mod, en_mod, fill_mod}, {32'h0, rd});
   endtask

   // Pin watcher: counts levels on falling edges, settled after each rising one
   always @(negedge CLK) begin
      if (RST) begin
         cur = '0;
         end_q = 1'b0;
         stb_q = 1'b0;
      end else begin
         if ((ALERT_STROBE || TEST_STROBE) && !stb_q) cur.cl = CONTROL_LINES;
         cur.al = cur.al + {3'h0, ALERT_STROBE};
         cur.bu = cur.bu + {3'h0, BUFFER_CONTROL_SELECT};
         cur.io = cur.io + {3'h0, IO_CHANNEL_SELECT};
         cur.sy = cur.sy + {3'h0, SYSTEM_SELECT};
         // Execution must open while alignment is false
         if (TIMING_PULSE_ONE && cur.q1 == 4'h0) cur.ta = CYCLE_ALIGN_STATE;
         cur.q1 = cur.q1 + {3'h0, TIMING_PULSE_ONE};
         cur.q2 = cur.q2 + {3'h0, TIMING_PULSE_TWO};
         cur.ts = cur.ts + {3'h0, TEST_STROBE};
         cur.en = cur.en + {3'h0, INSTRUCTION_END};
         cur.ib = cur.ib + {3'h0, INTERRUPT_BLOCK};
         // A result is complete when the end falls or the hand-off pulses
         if ((end_q && !INSTRUCTION_END) || FILL_HANDOFF === 1'b1) begin
            cur.fl = FILL_HANDOFF;
            cur.fg = FLAG_BIT;
            if (expq.size() == 0) begin
               err_count++;
               $display("Error result expected none seen %h", cur);
            end
            else chk("result", expq.pop_front(), cur);
            cur = '0;
         end
         end_q = INSTRUCTION_END;
         stb_q = ALERT_STROBE || TEST_STROBE;
      end
   end

   // Main sequence
   initial begin
      logic [31:0] rd;
      logic [16:0] r;
      void'($urandom(32'hA496));
      repeat (3) @(posedge CLK);
      RST <= 1'b0;
      bus(1'b0, 8'h04, 32'h0, rd);
      chk("ctrl_reset", 64'h0, {32'h0, rd});
      set_ctrl(4'h6);
      foreach (dir[i]) run(dir[i][16], dir[i][15], dir[i][14:0], 1'b0);
      // Random words, half forced onto the internal codes
      repeat (40) begin
         r = 17'($urandom);
         if ($urandom % 2) r = r & 17'h10FBF;
         ans_c = 1'($urandom);
         ans_s = 1'($urandom);
         BREAKPOINT_SWITCHES <= 4'($urandom);
         @(posedge CLK);
         if ($urandom % 4 == 0) set_ctrl(4'($urandom));
         run(r[16], r[15], r[14:0], 1'b0);
      end
      set_ctrl(4'h1);
      run(1'b0, 1'b1, 15'h1234, 1'b0);
      bus(1'b1, 8'h0C, 32'hFFFF_FFFF, rd);
      bus(1'b0, 8'h0C, 32'h0, rd);
      chk("fill_opcode", 64'h2D, {32'h0, rd});
      bus(1'b0, 8'h10, 32'h0, rd);
      chk("unmapped", 64'h0, {32'h0, rd});
      run(1'b0, 1'b0, 15'h2155, 1'b1);
      run(1'b1, 1'b0, 15'h1155, 1'b1);
      end_sim;
   end
endmodule
